/* src/synth_cfg_pkg.sv */
// constants shared by the synthesizer configuration logic
package synth_cfg_pkg;
	localparam int FEEDBACK_WIDTH = 9;
	localparam int OUTPUT_CODE_WIDTH = 3;
	localparam int OBSERVE_SEL_WIDTH = 2;
	localparam int SERIAL_WORD_BITS = 14;
	// serial word field positions, last shifted bit lands in bit 0
	localparam int SER_FEEDBACK_LSB = 0;
	localparam int SER_OUTPUT_LSB = 9;
	localparam int SER_OBSERVE_LSB = 12;
	localparam int REFERENCE_DIVIDE = 16;
	localparam int REFERENCE_COUNT_BITS = 4;
	localparam int PERIOD_BITS = 5;
	localparam int SYNC_STAGES = 3;
	// values after reset
	localparam logic [8:0] FEEDBACK_RESET = 9'h0FA;
	localparam logic [2:0] OUTPUT_CODE_RESET = 3'h0;
	localparam logic [1:0] OBSERVE_SEL_RESET = 2'h0;
	localparam logic [13:0] SHIFT_RESET = 14'h0000;
	localparam logic CONTROL_RESET = 1'b0;
	// register map, byte addresses
	localparam int APB_ADDR_WIDTH = 8;
	localparam logic [7:0] STATUS_OFFSET = 8'h00;
	localparam logic [7:0] CONTROL_OFFSET = 8'h04;
	// status word field positions
	localparam int STAT_FEEDBACK_LSB = 0;
	localparam int STAT_OUTPUT_LSB = 9;
	localparam int STAT_OBSERVE_LSB = 12;
	localparam int STAT_PARALLEL_BIT = 14;
	localparam int STAT_DIV_RESET_BIT = 15;
	localparam int CTRL_SOFT_RESET_BIT = 0;
	// observation output selections
	typedef enum logic [1:0] {
		OBS_LOW      = 2'h0,
		OBS_SERIAL   = 2'h1,
		OBS_FEEDBACK = 2'h2,
		OBS_CLOCK    = 2'h3
	} observe_type;
endpackage

/* src/pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input  wire logic             CLK,  // system clock
	input  wire logic             RST,  // synchronous reset, active high
	input  wire logic [WIDTH-1:0] DIN,  // asynchronous pin levels
	output logic      [WIDTH-1:0] DOUT  // filtered level
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] agree;

	if (WIDTH < 1) begin : g_width_check
		$error("pin_sync width must be positive");
	end

	// a bit changes only once stage two and three agree, so a one-cycle glitch is dropped
	assign agree = ~(s2_q ^ s3_q);

	always_ff @(posedge CLK) begin
		if (RST) begin
			s1_q <= RESET_VALUE;
			s2_q <= RESET_VALUE;
			s3_q <= RESET_VALUE;
			DOUT <= RESET_VALUE;
		end else begin
			s1_q <= DIN;
			s2_q <= s1_q;
			s3_q <= s2_q;
			DOUT <= (agree & s3_q) | (~agree & DOUT);
		end
	end
endmodule // pin_sync

/* src/synth_divider_config.sv */
// configuration logic and digital dividers of the frequency synthesizer
// What this block does
// - master reset high holds dividers; true outputs low, complement outputs high.
// - master reset low lets dividers run and outputs toggle.
// - master reset leaves loaded feedback, output and observe values alone.
// - parallel mode passes divide pins straight to the dividers.
// - observation output is low in parallel mode.
// - parallel strobe rising with transfer strobe low latches the divide pins.
// - serial mode shifts serial data in on each serial clock rise.
// - transfer strobe rising with serial clock low loads shift register into dividers.
// - transfer strobe falling keeps the current divide values held.
// - without a serial clock edge the shift register keeps its contents.
// - transfer strobe held high passes each shifted word straight to the dividers.
// - feedback divide is a 9-bit binary ratio, weights 1 to 256.
// - output code 0..7 gives ratios 1,1.5,2,3,4,6,8,12.
// - reference select high picks crystal, low picks test clock.
// - bypass select chooses between PLL path and bypass path.
// - observe bits pick low, serial input, feedback divider or output clock.
// - reference is divided by 16 before the phase compare.
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
module synth_divider_config
	import synth_cfg_pkg::*;
(
	input  wire logic        CLK,                      // 20 MHz system clock
	input  wire logic        RST,                      // synchronous reset, active high
	input  wire logic        MASTER_RESET,             // divider reset pin, active high
	input  wire logic        PARALLEL_LATCH_STROBE_N,  // parallel latch strobe, low = parallel mode
	input  wire logic        SERIAL_CLOCK,             // serial shift clock pin
	input  wire logic        SERIAL_DATA,              // serial data pin
	input  wire logic        SERIAL_TRANSFER_STROBE,   // serial transfer strobe pin
	input  wire logic [8:0]  FEEDBACK_DIVIDE_BITS,     // parallel feedback divide pins
	input  wire logic [2:0]  OUTPUT_DIVIDE_BITS,       // parallel output divide code pins
	input  wire logic        REFERENCE_SOURCE_SELECT,  // high = crystal, low = test clock
	input  wire logic        PLL_BYPASS_SELECT,        // high = PLL, low = bypass
	input  wire logic        CRYSTAL_CLOCK,            // oscillator reference pin
	input  wire logic        ALT_TEST_CLOCK,           // alternate test clock pin
	output logic      [1:0]  TRUE_CLOCK_OUTPUT,        // true clock outputs
	output logic      [1:0]  COMPLEMENT_CLOCK_OUTPUT,  // complementary clock outputs
	output logic             OBSERVE_OUTPUT,           // test observation output
	output logic             REFERENCE_DIV_OUT,        // reference divided by 16, to phase compare
	input  wire logic        PSEL,                     // APB select
	input  wire logic        PENABLE,                  // APB enable
	input  wire logic        PWRITE,                   // APB direction
	input  wire logic [7:0]  PADDR,                    // APB byte address
	input  wire logic [31:0] PWDATA,                   // APB write data
	output logic      [31:0] PRDATA,                   // APB read data
	output logic             PREADY,                   // APB ready
	output logic             PSLVERR                   // APB error on unmapped address
);
	localparam int PIN_COUNT = 21;

	// synchronised pin levels
	logic [PIN_COUNT-1:0] pins_raw;
	logic [PIN_COUNT-1:0] pins_lvl;
	logic                 mr_pin;
	logic                 parallel_n;
	logic                 sclk;
	logic                 sdata;
	logic                 sload;
	logic [8:0]           fb_pins;
	logic [2:0]           oc_pins;
	logic                 ref_sel;
	logic                 pll_sel;
	logic                 xtal;
	logic                 alt_clk;

	// edge history
	logic parallel_prev_q;
	logic sclk_prev_q;
	logic sload_prev_q;
	logic ref_prev_q;

	// configuration state
	logic [8:0]  feedback_q;
	logic [8:0]  feedback_d;
	logic [2:0]  out_code_q;
	logic [2:0]  out_code_d;
	logic [1:0]  observe_q;
	logic [1:0]  observe_d;
	logic [13:0] shift_q;
	logic [13:0] shift_d;

	// divider state
	logic [3:0]  ref_cnt_q;
	logic        ref_div_q;
	logic [8:0]  fb_cnt_q;
	logic        fb_out_q;
	logic [4:0]  out_cnt_q;
	logic        out_phase_q;
	logic [1:0]  true_q;
	logic [1:0]  comp_q;
	logic        observe_out_q;

	// bus state
	logic        soft_reset_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;

	// combinational terms
	logic        serial_mode;
	logic        sclk_rise;
	logic        sload_rise;
	logic        parallel_rise;
	logic        load_from_shift;
	logic        latch_pins;
	logic        div_reset;
	logic        ref_level;
	logic        ref_rise;
	logic        src_tick;
	logic [8:0]  fb_eff;
	logic [2:0]  oc_eff;
	logic [4:0]  out_period;
	logic [4:0]  out_high;
	logic        fb_wrap;
	logic        out_wrap;
	logic        obs_value;
	logic        access;
	logic        hit_status;
	logic        hit_control;
	logic [31:0] status_word;

	// ticks per output period, twice the ratio so the 1.5 ratio stays whole
	function automatic logic [4:0] period_of(input logic [2:0] code);
		logic [4:0] p;
		p = 5'h02;
		unique case (code)
			3'h0: p = 5'h02;
			3'h1: p = 5'h03;
			3'h2: p = 5'h04;
			3'h3: p = 5'h06;
			3'h4: p = 5'h08;
			3'h5: p = 5'h0C;
			3'h6: p = 5'h10;
			3'h7: p = 5'h18;
		endcase
		return p;
	endfunction

	assign pins_raw = {MASTER_RESET, PARALLEL_LATCH_STROBE_N, SERIAL_CLOCK, SERIAL_DATA, SERIAL_TRANSFER_STROBE,
		FEEDBACK_DIVIDE_BITS, OUTPUT_DIVIDE_BITS, REFERENCE_SOURCE_SELECT, PLL_BYPASS_SELECT, CRYSTAL_CLOCK,
		ALT_TEST_CLOCK};

	pin_sync #(
		.WIDTH       (PIN_COUNT),
		.RESET_VALUE ({PIN_COUNT{1'b0}})
	) u_pin_sync (
		.CLK  (CLK),
		.RST  (RST),
		.DIN  (pins_raw),
		.DOUT (pins_lvl)
	);

	assign {mr_pin, parallel_n, sclk, sdata, sload, fb_pins, oc_pins, ref_sel, pll_sel, xtal, alt_clk} = pins_lvl;

	// edge detection on the filtered levels
	assign serial_mode   = parallel_n;
	assign sclk_rise     = sclk & ~sclk_prev_q;
	assign sload_rise    = sload & ~sload_prev_q;
	assign parallel_rise = parallel_n & ~parallel_prev_q;

	// serial clock edges shift in both strobe states
	assign shift_d = (serial_mode && sclk_rise) ? {shift_q[12:0], sdata} : shift_q;
	// transfer on strobe rise with clock low, or on each clock rise while the strobe is held high
	assign load_from_shift = serial_mode & ((sload_rise & ~sclk) | (sload & sclk_rise));
	assign latch_pins      = parallel_rise & ~sload;

	// strobe falling needs no action: the held registers simply stop being reloaded
	assign feedback_d = load_from_shift ? shift_d[SER_FEEDBACK_LSB +: FEEDBACK_WIDTH] :
		latch_pins ? fb_pins : feedback_q;
	assign out_code_d = load_from_shift ? shift_d[SER_OUTPUT_LSB +: OUTPUT_CODE_WIDTH] :
		latch_pins ? oc_pins : out_code_q;
	assign observe_d  = load_from_shift ? shift_d[SER_OBSERVE_LSB +: OBSERVE_SEL_WIDTH] : observe_q;

	// parallel mode is transparent to the pins
	assign fb_eff = serial_mode ? feedback_q : fb_pins;
	assign oc_eff = serial_mode ? out_code_q : oc_pins;

	// master reset touches the dividers only, never the configuration registers
	assign div_reset = mr_pin | soft_reset_q;

	// reference and source selection
	assign ref_level = ref_sel ? xtal : alt_clk;
	assign ref_rise  = ref_level & ~ref_prev_q;
	// the system clock stands in for the oscillator, so the loop is always taken as locked
	assign src_tick  = pll_sel ? 1'b1 : ref_rise;

	// feedback divider wraps after a count of the divide value; zero behaves like one
	assign fb_wrap  = (fb_cnt_q + 9'h001 >= fb_eff);
	assign out_period = period_of(oc_eff);
	assign out_high   = {1'b0, out_period[4:1]};
	assign out_wrap   = (out_cnt_q + 5'h01 >= out_period);

	// observation selection; parallel mode forces low
	assign obs_value = !serial_mode ? 1'b0 :
		(observe_q == OBS_SERIAL)   ? sdata :
		(observe_q == OBS_FEEDBACK) ? fb_out_q :
		(observe_q == OBS_CLOCK)    ? out_phase_q : 1'b0;

	// bus decode
	assign access      = PSEL & PENABLE & ~pready_q;
	assign hit_status  = (PADDR == STATUS_OFFSET);
	assign hit_control = (PADDR == CONTROL_OFFSET);
	assign status_word = {16'h0000, div_reset, ~serial_mode, observe_q, oc_eff, fb_eff};

	always_ff @(posedge CLK) begin
		if (RST) begin
			parallel_prev_q <= 1'b0;
			sclk_prev_q     <= 1'b0;
			sload_prev_q    <= 1'b0;
			ref_prev_q      <= 1'b0;
			feedback_q      <= FEEDBACK_RESET;
			out_code_q      <= OUTPUT_CODE_RESET;
			observe_q       <= OBSERVE_SEL_RESET;
			shift_q         <= SHIFT_RESET;
		end else begin
			parallel_prev_q <= parallel_n;
			sclk_prev_q     <= sclk;
			sload_prev_q    <= sload;
			ref_prev_q      <= ref_level;
			feedback_q      <= feedback_d;
			out_code_q      <= out_code_d;
			observe_q       <= observe_d;
			shift_q         <= shift_d;
		end
	end

	// reference divide-by-16 runs off the selected reference, square output
	always_ff @(posedge CLK) begin
		if (RST || div_reset) begin
			ref_cnt_q <= 4'h0;
			ref_div_q <= 1'b0;
		end else if (ref_rise) begin
			ref_cnt_q <= ref_cnt_q + 4'h1;
			ref_div_q <= (ref_cnt_q + 4'h1 >= 4'(REFERENCE_DIVIDE / 2));
		end
	end

	always_ff @(posedge CLK) begin
		if (RST || div_reset) begin
			fb_cnt_q <= 9'h000;
			fb_out_q <= 1'b0;
		end else if (src_tick) begin
			fb_cnt_q <= fb_wrap ? 9'h000 : fb_cnt_q + 9'h001;
			fb_out_q <= fb_wrap ? ~fb_out_q : fb_out_q;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST || div_reset) begin
			out_cnt_q   <= 5'h00;
			out_phase_q <= 1'b0;
		end else if (src_tick) begin
			out_cnt_q   <= out_wrap ? 5'h00 : out_cnt_q + 5'h01;
			out_phase_q <= out_wrap ? 1'b1 : (out_cnt_q + 5'h01 < out_high);
		end
	end

	// pins follow the divider one cycle later, and are forced while it is held
	always_ff @(posedge CLK) begin
		if (RST || div_reset) begin
			true_q <= 2'b00;
			comp_q <= 2'b11;
		end else begin
			true_q <= {2{out_phase_q}};
			comp_q <= {2{~out_phase_q}};
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			observe_out_q <= 1'b0;
		end else begin
			observe_out_q <= obs_value;
		end
	end

	// APB slave: one wait state, so every transfer ends at the second access edge
	always_ff @(posedge CLK) begin
		if (RST) begin
			soft_reset_q <= CONTROL_RESET;
			prdata_q     <= 32'h00000000;
			pready_q     <= 1'b0;
			pslverr_q    <= 1'b0;
		end else begin
			pready_q  <= access;
			pslverr_q <= access & ~hit_status & ~hit_control;
			prdata_q  <= (access && !PWRITE && hit_status) ? status_word :
				(access && !PWRITE && hit_control) ? {31'h00000000, soft_reset_q} : 32'h00000000;
			if (PSEL && PENABLE && pready_q && PWRITE && hit_control) begin
				soft_reset_q <= PWDATA[CTRL_SOFT_RESET_BIT];
			end
		end
	end

	assign TRUE_CLOCK_OUTPUT       = true_q;
	assign COMPLEMENT_CLOCK_OUTPUT = comp_q;
	assign OBSERVE_OUTPUT          = observe_out_q;
	assign REFERENCE_DIV_OUT       = ref_div_q;
	assign PRDATA                  = prdata_q;
	assign PREADY                  = pready_q;
	assign PSLVERR                 = pslverr_q;
endmodule // synth_divider_config

/* test/synth_divider_config_asserts.sv */
// port-level assertions for the synthesizer configuration logic
`timescale 1ns/1ps
module synth_divider_config_asserts
	import synth_cfg_pkg::*;
(
	input wire logic        CLK,                      // system clock
	input wire logic        RST,                      // synchronous reset
	input wire logic        MASTER_RESET,             // divider reset pin
	input wire logic        PARALLEL_LATCH_STROBE_N,  // low = parallel mode
	input wire logic        PLL_BYPASS_SELECT,        // high = PLL
	input wire logic [1:0]  TRUE_CLOCK_OUTPUT,        // true outputs
	input wire logic [1:0]  COMPLEMENT_CLOCK_OUTPUT,  // complement outputs
	input wire logic        OBSERVE_OUTPUT,           // observation output
	input wire logic        PSEL,                     // APB select
	input wire logic        PENABLE,                  // APB enable
	input wire logic        PWRITE,                   // APB direction
	input wire logic [7:0]  PADDR,                    // APB address
	input wire logic [31:0] PWDATA,                   // APB write data
	input wire logic [31:0] PRDATA,                   // APB read data
	input wire logic        PREADY,                   // APB ready
	input wire logic        PSLVERR                   // APB error
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	logic [7:0] stuck_q;
	logic [1:0] last_q;
	logic       soft_q;
	// soft reset is tracked from the bus so a held divider is not taken for a stuck one
	always_ff @(posedge CLK) begin
		last_q <= TRUE_CLOCK_OUTPUT;
		if (RST)
			soft_q <= 1'b0;
		else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == CONTROL_OFFSET)
			soft_q <= PWDATA[CTRL_SOFT_RESET_BIT];
		stuck_q <= (RST || MASTER_RESET || soft_q || !PLL_BYPASS_SELECT || TRUE_CLOCK_OUTPUT != last_q)
			? 8'h00 : stuck_q + 8'h01;
	end
	chk_out_inverse: assert property (COMPLEMENT_CLOCK_OUTPUT == ~TRUE_CLOCK_OUTPUT)
		else $error("complement output not inverse");
	chk_reset_hold: assert property (MASTER_RESET [*7] |->
		TRUE_CLOCK_OUTPUT == 2'h0 && COMPLEMENT_CLOCK_OUTPUT == 2'h3) else $error("outputs not held");
	chk_outputs_run: assert property (stuck_q < 8'h28)
		else $error("outputs stopped while running");
	chk_obs_parallel: assert property ((!PARALLEL_LATCH_STROBE_N) [*7] |-> !OBSERVE_OUTPUT)
		else $error("observe high in parallel mode");
	chk_ready_answer: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("ready late");
	chk_ready_single: assert property (PREADY |=> !PREADY)
		else $error("ready longer than one cycle");
	chk_ready_gated: assert property (PREADY |-> PSEL && PENABLE)
		else $error("ready outside access phase");
	chk_err_unmapped: assert property (PREADY |->
		PSLVERR == !(PADDR == STATUS_OFFSET || PADDR == CONTROL_OFFSET)) else $error("wrong error response");
	chk_err_nodata: assert property (PSLVERR |-> PRDATA == 32'h0)
		else $error("data with error response");
endmodule  // synth_divider_config_asserts

bind synth_divider_config synth_divider_config_asserts synth_divider_config_asserts_inst (.*);

/* test/serial_controller.sv */
// model of the external controller driving the serial load pins
`timescale 1ns/1ps
module serial_controller (
	input  wire logic CLK,                     // system clock
	output logic      SERIAL_CLOCK,            // shift clock, idle low
	output logic      SERIAL_DATA,             // data, pulled low when released
	output logic      SERIAL_TRANSFER_STROBE   // transfer strobe
);
	initial begin
		SERIAL_CLOCK = 1'b0;
		SERIAL_DATA = 1'b0;
		SERIAL_TRANSFER_STROBE = 1'b0;
	end
	// mode 0 shifts only, 1 shifts then pulses the strobe, 2 shifts with the strobe held high
	task automatic send(input logic [13:0] word, input int hold, input int mode);
		if (mode == 2)
			SERIAL_TRANSFER_STROBE <= 1'b1;
		for (int i = 13; i >= 0; i--) begin
			SERIAL_DATA <= word[i];
			repeat (hold) @(posedge CLK);
			SERIAL_CLOCK <= 1'b1;
			repeat (hold) @(posedge CLK);
			SERIAL_CLOCK <= 1'b0;
		end
		repeat (hold) @(posedge CLK);
		SERIAL_DATA <= 1'b0;
		if (mode == 1) begin
			SERIAL_TRANSFER_STROBE <= 1'b1;
			repeat (hold) @(posedge CLK);
		end
		SERIAL_TRANSFER_STROBE <= 1'b0;
		repeat (hold) @(posedge CLK);
	endtask
endmodule  // serial_controller

/* test/tb.sv */
// self-checking bench for the synthesizer configuration logic
`timescale 1ns/1ps
module tb;
	import synth_cfg_pkg::*;
	logic        CLK = 0, RST = 1, MASTER_RESET = 0, PARALLEL_LATCH_STROBE_N = 0;
	logic        REFERENCE_SOURCE_SELECT = 1, PLL_BYPASS_SELECT = 1, CRYSTAL_CLOCK = 0, ALT_TEST_CLOCK = 0;
	logic [8:0]  FEEDBACK_DIVIDE_BITS = 9'h0FA, m;
	logic [2:0]  OUTPUT_DIVIDE_BITS = 3'h0, n;
	logic        PSEL = 0, PENABLE = 0, PWRITE = 0, OBSERVE_OUTPUT, REFERENCE_DIV_OUT, PREADY, PSLVERR, er;
	logic [7:0]  PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA, rd;
	logic [1:0]  TRUE_CLOCK_OUTPUT, COMPLEMENT_CLOCK_OUTPUT;
	wire logic   SERIAL_CLOCK, SERIAL_DATA, SERIAL_TRANSFER_STROBE;
	logic [15:0] seed = 16'h005B;
	int          n_mismatch = 0, n_checks = 0, cyc = 0, xc = 0, ac = 0, p;
	synth_divider_config synth_divider_config_inst (.*);
	serial_controller serial_controller_inst (.*);
	always #25 CLK = ~CLK;
	// two unrelated reference rates, 6 and 8 clocks per period
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		xc <= (xc == 2) ? 0 : xc + 1;
		ac <= (ac == 3) ? 0 : ac + 1;
		if (xc == 2) CRYSTAL_CLOCK <= ~CRYSTAL_CLOCK;
		if (ac == 3) ALT_TEST_CLOCK <= ~ALT_TEST_CLOCK;
		if (cyc == 20000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	function automatic logic [15:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction
	function automatic logic [8:0] pick_m();
		return 9'(250 + rnd() % 251);
	endfunction
	function automatic int ticks(logic [2:0] c);
		int t[8] = '{2, 3, 4, 6, 8, 12, 16, 24};
		return t[c];
	endfunction
	function automatic logic [15:0] stat(logic [1:0] o, logic [2:0] c, logic [8:0] f, logic par, logic held);
		return {held, par, o, c, f};
	endfunction
	function automatic logic sig(int s);
		return s == 0 ? TRUE_CLOCK_OUTPUT[0] : (s == 1 ? OBSERVE_OUTPUT : REFERENCE_DIV_OUT);
	endfunction
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic status(input logic [15:0] e);
		apb(0, STATUS_OFFSET, 32'h0, rd, er);
		check("status", {16'h0, rd[15:0]}, {16'h0, e});
	endtask
	task automatic cycles(int k);
		repeat (k) @(posedge CLK);
	endtask
	// rising edge to rising edge, in clock cycles
	task automatic period(input int s, output int q);
		logic a, b;
		a = sig(s);
		q = -1;
		for (int k = 0; k < 3000; k++) begin
			@(posedge CLK);
			b = sig(s);
			if (b === 1'b1 && a === 1'b0 && q > 0) break;
			if (b === 1'b1 && a === 1'b0) q = 0;
			if (q >= 0) q++;
			a = b;
		end
	endtask
	task automatic mreset(input logic [15:0] e);
		MASTER_RESET <= 1'b1;
		cycles(8);
		check("true_held", 32'(TRUE_CLOCK_OUTPUT), 32'h0);
		check("comp_held", 32'(COMPLEMENT_CLOCK_OUTPUT), 32'h3);
		status(e);
		MASTER_RESET <= 1'b0;
		cycles(8);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		cycles(12);
		RST <= 1'b0;
		// synchronisers restart from zero at release, so let the pin levels settle first
		cycles(8);
		status(stat(0, 0, 9'h0FA, 1, 0));
		apb(0, 8'h08, 32'h0, rd, er);
		check("unmapped_err", 32'(er), 32'h1);
		check("unmapped_data", rd, 32'h0);
		apb(1, STATUS_OFFSET, 32'hFFFF, rd, er);
		status(stat(0, 0, 9'h0FA, 1, 0));
		apb(1, CONTROL_OFFSET, 32'h1, rd, er);
		apb(0, CONTROL_OFFSET, 32'h0, rd, er);
		check("control", rd, 32'h1);
		status(stat(0, 0, 9'h0FA, 1, 1));
		apb(1, CONTROL_OFFSET, 32'h0, rd, er);
		for (int c = 0; c < 8; c++) begin
			m = pick_m();
			FEEDBACK_DIVIDE_BITS <= m;
			OUTPUT_DIVIDE_BITS <= 3'(c);
			cycles(8);
			status(stat(0, 3'(c), m, 1, 0));
			check("observe_low", 32'(OBSERVE_OUTPUT), 32'h0);
			period(0, p);
			check("out_period", p, ticks(3'(c)));
		end
		OUTPUT_DIVIDE_BITS <= 3'h0;
		PLL_BYPASS_SELECT <= 1'b0;
		for (int s = 1; s >= 0; s--) begin
			REFERENCE_SOURCE_SELECT <= s[0];
			cycles(150);
			period(0, p);
			check("bypass_period", p, s ? 12 : 16);
			period(2, p);
			check("ref_period", p, s ? 96 : 128);
		end
		PLL_BYPASS_SELECT <= 1'b1;
		m = pick_m();
		n = 3'(rnd());
		FEEDBACK_DIVIDE_BITS <= m;
		OUTPUT_DIVIDE_BITS <= n;
		cycles(8);
		PARALLEL_LATCH_STROBE_N <= 1'b1;
		cycles(8);
		FEEDBACK_DIVIDE_BITS <= ~m;
		OUTPUT_DIVIDE_BITS <= ~n;
		cycles(8);
		status(stat(0, n, m, 0, 0));
		for (int o = 0; o < 4; o++) begin
			m = pick_m();
			n = 3'(rnd());
			serial_controller_inst.send({2'(o), n, m}, 4 + 5 * int'(rnd() % 2), 1);
			status(stat(2'(o), n, m, 0, 0));
			if (o < 2)
				check("observe", 32'(OBSERVE_OUTPUT), 32'h0);
			else begin
				period(1, p);
				check("observe_period", p, o == 2 ? 2 * m : ticks(n));
			end
		end
		serial_controller_inst.send(~{2'h3, n, m}, 4, 0);
		status(stat(3, n, m, 0, 0));
		m = pick_m();
		n = 3'(rnd());
		serial_controller_inst.send({2'h0, n, m}, 4, 2);
		status(stat(0, n, m, 0, 0));
		mreset(stat(0, n, m, 0, 1));
		period(0, p);
		check("run_period", p, ticks(n));
		give_verdict();
	end
endmodule  // tb
